// ---- common/cpuodt_pkg.sv ----
// Purpose: Shared constants and types for the opcode decode and timing block.
// Assumes: One clk cycle stands for one processor state.
// Notes: Opcode values and state counts are named here once.
package cpuodt_pkg;

	// Register field codes.
	localparam logic [2:0] REG_B = 3'h0;
	localparam logic [2:0] REG_C = 3'h1;
	localparam logic [2:0] REG_D = 3'h2;
	localparam logic [2:0] REG_E = 3'h3;
	localparam logic [2:0] REG_H = 3'h4;
	localparam logic [2:0] REG_L = 3'h5;
	localparam logic [2:0] REG_MEM = 3'h6;
	localparam logic [2:0] REG_A = 3'h7;

	// Opcode values and the pattern of the XOR group, covering both the register and the memory forms.
	localparam logic [7:0] OPC_SWAP_STACK_TOP_HL = 8'hE3;
	localparam logic [7:0] OPC_SWAP_DE_HL = 8'hEB;
	localparam logic [7:0] OPC_SUB_IMMEDIATE = 8'hD6;
	localparam logic [7:0] OPC_XOR_GROUP = 8'hA8;
	localparam logic [7:0] OPC_XOR_GROUP_MASK = 8'hF8;
	localparam logic [7:0] OPC_RETURN_IF_PARITY_EVEN = 8'hE8;
	localparam logic [7:0] OPC_RETURN_IF_PARITY_ODD = 8'hE0;
	localparam logic [7:0] OPC_PAIR_INCREMENT_DE = 8'h13;
	localparam logic [7:0] OPC_PAIR_INCREMENT_HL = 8'h23;

	// State counts per instruction.
	localparam logic [4:0] ST_SWAP_STACK_TOP_HL = 5'h12;
	localparam logic [4:0] ST_SWAP_DE_HL = 5'h04;
	localparam logic [4:0] ST_SUB_IMMEDIATE = 5'h07;
	localparam logic [4:0] ST_XOR_MEM = 5'h07;
	localparam logic [4:0] ST_XOR_REG = 5'h04;
	localparam logic [4:0] ST_RET_NOT_TAKEN = 5'h05;
	localparam logic [4:0] ST_RET_TAKEN = 5'h0B;
	localparam logic [4:0] ST_PAIR_INCREMENT = 5'h05;
	localparam logic [4:0] ST_UNDECODED = 5'h04;

	// Pair selectors.
	localparam logic PAIR_DE = 1'b0;
	localparam logic PAIR_HL = 1'b1;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_SWAP_STACK_TOP_HL,
		OP_SWAP_DE_HL,
		OP_SUB_IMMEDIATE,
		OP_XOR_INTO_ACC,
		OP_RETURN_IF_PARITY_EVEN,
		OP_RETURN_IF_PARITY_ODD,
		OP_PAIR_INCREMENT
	} cpuodt_op_e;

	typedef struct packed {
		cpuodt_op_e op;
		logic [2:0] dest_reg_field;
		logic [2:0] src_reg_field;
		logic mem_at_hl;
		logic needs_imm;
		logic pair_sel;
		logic ret_taken;
		logic [4:0] states;
	} cpuodt_dec_s;

endpackage : cpuodt_pkg

// ---- hdl/cpuodt_decode.sv ----
// Purpose: Decode one opcode byte into its operation, register fields and state count.
// Assumes: Opcode bytes and the parity flag are synchronous to clk.
// Notes: The block holds itself busy for the instruction's state count.
// Summary of operation
// - Register fields: 000 B, 001 C, 010 D, 011 E, 100 H, 101 L, 110 memory, 111 A.
// - Two-count instructions pick short or long count from the tested flag.
// - Opcode E3 swaps HL with stack top, 18 states.
// - Opcode EB swaps DE with HL, 4 states.
// - Opcode D6 subtracts immediate byte from A, 7 states.
// - Opcode AE XORs memory at HL into A, 7 states.
// - Opcodes 10101sss with sss not 110 XOR selected register into A, 4 states.
// - Opcode E8 returns only on even parity, 5 or 11 states.
// - Opcode E0 returns only on odd parity, 5 or 11 states.
// - Opcode 13 increments pair DE as one value, 5 states.
// - Opcode 23 increments pair HL as one value, 5 states.
`timescale 1ns/1ps
`default_nettype none

module cpuodt_decode (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic op_valid,
	input wire logic [7:0] op_byte,
	input wire logic parity_flag,
	output logic ready_ff,
	output logic dec_valid_ff,
	output cpuodt_pkg::cpuodt_dec_s dec_ff,
	output logic done_ff
);
	import cpuodt_pkg::*;

	typedef enum logic {
		CPUODT_IDLE,
		CPUODT_RUN
	} cpuodt_state_e;

	cpuodt_state_e state_ff;
	cpuodt_dec_s nxt_dec;
	logic [4:0] cnt_ff;
	logic accept;

	assign accept = op_valid && ready_ff;

	always_comb begin
		nxt_dec = '0;
		nxt_dec.op = OP_NONE;
		nxt_dec.states = ST_UNDECODED;
		if (op_byte == OPC_SWAP_STACK_TOP_HL) begin
			nxt_dec.op = OP_SWAP_STACK_TOP_HL;
			nxt_dec.pair_sel = PAIR_HL;
			nxt_dec.states = ST_SWAP_STACK_TOP_HL;
		end else if (op_byte == OPC_SWAP_DE_HL) begin
			nxt_dec.op = OP_SWAP_DE_HL;
			nxt_dec.states = ST_SWAP_DE_HL;
		end else if (op_byte == OPC_SUB_IMMEDIATE) begin
			nxt_dec.op = OP_SUB_IMMEDIATE;
			nxt_dec.dest_reg_field = REG_A;
			nxt_dec.needs_imm = 1'b1;
			nxt_dec.states = ST_SUB_IMMEDIATE;
		end else if ((op_byte & OPC_XOR_GROUP_MASK) == OPC_XOR_GROUP) begin
			nxt_dec.op = OP_XOR_INTO_ACC;
			nxt_dec.dest_reg_field = REG_A;
			nxt_dec.src_reg_field = op_byte[2:0];
			if (op_byte[2:0] == REG_MEM) begin
				nxt_dec.mem_at_hl = 1'b1;
				nxt_dec.states = ST_XOR_MEM;
			end else begin
				nxt_dec.states = ST_XOR_REG;
			end
		end else if (op_byte == OPC_RETURN_IF_PARITY_EVEN) begin
			nxt_dec.op = OP_RETURN_IF_PARITY_EVEN;
			nxt_dec.ret_taken = parity_flag;
			nxt_dec.states = parity_flag ? ST_RET_TAKEN : ST_RET_NOT_TAKEN;
		end else if (op_byte == OPC_RETURN_IF_PARITY_ODD) begin
			nxt_dec.op = OP_RETURN_IF_PARITY_ODD;
			nxt_dec.ret_taken = !parity_flag;
			nxt_dec.states = parity_flag ? ST_RET_NOT_TAKEN : ST_RET_TAKEN;
		end else if (op_byte == OPC_PAIR_INCREMENT_DE) begin
			nxt_dec.op = OP_PAIR_INCREMENT;
			nxt_dec.pair_sel = PAIR_DE;
			nxt_dec.states = ST_PAIR_INCREMENT;
		end else if (op_byte == OPC_PAIR_INCREMENT_HL) begin
			nxt_dec.op = OP_PAIR_INCREMENT;
			nxt_dec.pair_sel = PAIR_HL;
			nxt_dec.states = ST_PAIR_INCREMENT;
		end
	end

	// The decode result is held for the whole instruction so the datapath can read it late.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dec_ff <= '0;
		end else if (accept) begin
			dec_ff <= nxt_dec;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dec_valid_ff <= 1'b0;
		end else begin
			dec_valid_ff <= accept;
		end
	end

	// The parity flag is sampled with the opcode; a later flag change cannot stretch a return.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= CPUODT_IDLE;
			cnt_ff <= 5'h00;
			ready_ff <= 1'b1;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			case (state_ff)
				CPUODT_IDLE: begin
					if (accept) begin
						state_ff <= CPUODT_RUN;
						cnt_ff <= nxt_dec.states - 5'h01;
						ready_ff <= 1'b0;
					end
				end
				CPUODT_RUN: begin
					if (cnt_ff == 5'h00) begin
						state_ff <= CPUODT_IDLE;
						ready_ff <= 1'b1;
						done_ff <= 1'b1;
					end else begin
						cnt_ff <= cnt_ff - 5'h01;
					end
				end
				default: begin
					state_ff <= CPUODT_IDLE;
					ready_ff <= 1'b1;
				end
			endcase
		end
	end

	AST_XOR_FIELDS: assert property (@(posedge clk) disable iff (!rst_n)
		dec_valid_ff && dec_ff.op == OP_XOR_INTO_ACC |->
		dec_ff.dest_reg_field == REG_A && dec_ff.src_reg_field == $past(op_byte[2:0]))
		else $error("XOR register fields wrong");

	AST_RET_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
		dec_valid_ff && (dec_ff.op == OP_RETURN_IF_PARITY_EVEN ||
		dec_ff.op == OP_RETURN_IF_PARITY_ODD) |->
		dec_ff.states == (dec_ff.ret_taken ? ST_RET_TAKEN : ST_RET_NOT_TAKEN))
		else $error("Return state count does not follow the condition");

	AST_SWAP_STACK_LEN: assert property (@(posedge clk) disable iff (!rst_n)
		dec_valid_ff && dec_ff.op == OP_SWAP_STACK_TOP_HL |-> ##18 done_ff)
		else $error("Stack swap did not end after 18 states");

	AST_SWAP_DE_HL_LEN: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(dec_valid_ff) && dec_ff.op == OP_SWAP_DE_HL |-> !done_ff[*4] ##1 done_ff)
		else $error("DE HL swap did not end after 4 states");

	AST_SUB_IMM: assert property (@(posedge clk) disable iff (!rst_n)
		accept && op_byte == OPC_SUB_IMMEDIATE |->
		##1 dec_ff.needs_imm && dec_ff.op == OP_SUB_IMMEDIATE ##7 done_ff)
		else $error("Immediate subtract decode or length wrong");

	AST_XOR_MEM: assert property (@(posedge clk) disable iff (!rst_n)
		accept && (op_byte & OPC_XOR_GROUP_MASK) == OPC_XOR_GROUP && op_byte[2:0] == REG_MEM |->
		##1 dec_ff.mem_at_hl && dec_ff.states == ST_XOR_MEM)
		else $error("XOR memory form decode wrong");

	AST_XOR_REG_LEN: assert property (@(posedge clk) disable iff (!rst_n)
		dec_valid_ff && dec_ff.op == OP_XOR_INTO_ACC && !dec_ff.mem_at_hl |-> ##4 done_ff)
		else $error("XOR register form not 4 states");

	AST_RPE_TAKEN: assert property (@(posedge clk) disable iff (!rst_n)
		accept && op_byte == OPC_RETURN_IF_PARITY_EVEN |->
		##1 dec_ff.ret_taken == $past(parity_flag))
		else $error("Even parity return condition wrong");

	AST_RPO_TAKEN: assert property (@(posedge clk) disable iff (!rst_n)
		accept && op_byte == OPC_RETURN_IF_PARITY_ODD && parity_flag |->
		##1 !dec_ff.ret_taken ##5 done_ff)
		else $error("Odd parity return not skipped in 5 states");

	AST_INX_DE: assert property (@(posedge clk) disable iff (!rst_n)
		accept && op_byte == OPC_PAIR_INCREMENT_DE |->
		##1 dec_ff.op == OP_PAIR_INCREMENT && dec_ff.pair_sel == PAIR_DE ##5 done_ff)
		else $error("DE increment decode or length wrong");

	AST_INX_HL: assert property (@(posedge clk) disable iff (!rst_n)
		accept && op_byte == OPC_PAIR_INCREMENT_HL |->
		##1 dec_ff.pair_sel == PAIR_HL && dec_ff.states == ST_PAIR_INCREMENT)
		else $error("HL increment decode wrong");

	AST_MEM_VIA_HL: assert property (@(posedge clk) disable iff (!rst_n)
		dec_valid_ff && dec_ff.op == OP_XOR_INTO_ACC |->
		dec_ff.mem_at_hl == (dec_ff.src_reg_field == REG_MEM))
		else $error("Memory operand not tied to HL addressing");

	// A taken return must also spend the long count, not only flag it.
	AST_RPE_LONG: assert property (@(posedge clk) disable iff (!rst_n)
		accept && op_byte == OPC_RETURN_IF_PARITY_EVEN && parity_flag |->
		##1 dec_ff.ret_taken ##11 done_ff)
		else $error("Even parity return not taken in 11 states");

	AST_RPO_LONG: assert property (@(posedge clk) disable iff (!rst_n)
		accept && op_byte == OPC_RETURN_IF_PARITY_ODD && !parity_flag |->
		##1 dec_ff.ret_taken ##11 done_ff)
		else $error("Odd parity return not taken in 11 states");

	AST_XOR_MEM_LEN: assert property (@(posedge clk) disable iff (!rst_n)
		accept && (op_byte & OPC_XOR_GROUP_MASK) == OPC_XOR_GROUP && op_byte[2:0] == REG_MEM |->
		##8 done_ff)
		else $error("XOR memory form not 7 states");

	// Requests offered while a count runs are refused, so ready must stay low.
	AST_BUSY_WHILE_RUN: assert property (@(posedge clk) disable iff (!rst_n)
		dec_valid_ff |-> !ready_ff)
		else $error("Ready high while an instruction runs");

	AST_DONE_RELEASES: assert property (@(posedge clk) disable iff (!rst_n)
		done_ff |-> ready_ff && !dec_valid_ff)
		else $error("Done without ready");

endmodule : cpuodt_decode

`default_nettype wire

// ---- verif/cpuodt_decode_tb.sv ----
// Purpose: Self-checking bench for the opcode decode and timing block.
// Assumes: One clk cycle is one processor state.
// Notes: State counts are measured from the decode pulse to the done pulse.
`timescale 1ns/1ps
`default_nettype none

module cpuodt_decode_tb;
	import cpuodt_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic go = 1'b0;
	logic parity_flag = 1'b0;
	logic [7:0] byte_in = 8'h00;
	logic op_valid;
	logic [7:0] op_byte;
	logic ready_ff;
	logic dec_valid_ff;
	logic done_ff;
	cpuodt_dec_s dec_ff;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;

	initial forever #2.5 clk = ~clk;

	cpuodt_progmem i_cpuodt_progmem (.clk(clk), .rst_n(rst_n), .go(go), .byte_in(byte_in),
		.ready_ff(ready_ff), .op_valid(op_valid), .op_byte(op_byte));
	cpuodt_decode i_cpuodt_decode (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
		.op_byte(op_byte), .parity_flag(parity_flag), .ready_ff(ready_ff),
		.dec_valid_ff(dec_valid_ff), .dec_ff(dec_ff), .done_ff(done_ff));

	task print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Offers one byte, then judges the decode and the measured state count.
	task run(input logic [7:0] b, input logic par, input logic [7:0] op, input logic [7:0] dst,
		input logic [7:0] src, input logic [7:0] mem, input logic [7:0] st);
		int n;
		@(negedge clk);
		byte_in = b;
		parity_flag = par;
		go = 1'b1;
		n = 0;
		while (dec_valid_ff !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		go = 1'b0;
		check("op", 8'(dec_ff.op), op);
		check("dest", 8'(dec_ff.dest_reg_field), dst);
		check("src", 8'(dec_ff.src_reg_field), src);
		check("mem_at_hl", 8'(dec_ff.mem_at_hl), mem);
		check("states field", 8'(dec_ff.states), st);
		n = 0;
		while (done_ff !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		check("states spent", 8'(n), st);
		check("ready", 8'(ready_ff), 8'h01);
	endtask : run

	task t_xor;
		for (int i = 0; i < 8; i++) begin
			run(8'hA8 + 8'(i), 1'b0, 8'(OP_XOR_INTO_ACC), 8'h07, 8'(i), 8'(i == 6),
				(i == 6) ? 8'h07 : 8'h04);
		end
	endtask : t_xor

	task t_swap;
		run(8'hE3, 1'b0, 8'(OP_SWAP_STACK_TOP_HL), 8'h00, 8'h00, 8'h00, 8'h12);
		check("pair", 8'(dec_ff.pair_sel), 8'h01);
		run(8'hEB, 1'b0, 8'(OP_SWAP_DE_HL), 8'h00, 8'h00, 8'h00, 8'h04);
	endtask : t_swap

	task t_sub;
		run(8'hD6, 1'b0, 8'(OP_SUB_IMMEDIATE), 8'h07, 8'h00, 8'h00, 8'h07);
		check("needs_imm", 8'(dec_ff.needs_imm), 8'h01);
	endtask : t_sub

	// Both parities on both conditional returns, taken and not taken.
	task t_ret;
		run(8'hE8, 1'b1, 8'(OP_RETURN_IF_PARITY_EVEN), 8'h00, 8'h00, 8'h00, 8'h0B);
		check("ret_taken", 8'(dec_ff.ret_taken), 8'h01);
		run(8'hE8, 1'b0, 8'(OP_RETURN_IF_PARITY_EVEN), 8'h00, 8'h00, 8'h00, 8'h05);
		run(8'hE0, 1'b0, 8'(OP_RETURN_IF_PARITY_ODD), 8'h00, 8'h00, 8'h00, 8'h0B);
		run(8'hE0, 1'b1, 8'(OP_RETURN_IF_PARITY_ODD), 8'h00, 8'h00, 8'h00, 8'h05);
		check("ret_taken", 8'(dec_ff.ret_taken), 8'h00);
	endtask : t_ret

	task t_pair;
		run(8'h13, 1'b0, 8'(OP_PAIR_INCREMENT), 8'h00, 8'h00, 8'h00, 8'h05);
		check("pair", 8'(dec_ff.pair_sel), 8'h00);
		run(8'h23, 1'b0, 8'(OP_PAIR_INCREMENT), 8'h00, 8'h00, 8'h00, 8'h05);
		check("pair", 8'(dec_ff.pair_sel), 8'h01);
		run(8'h00, 1'b0, 8'(OP_NONE), 8'h00, 8'h00, 8'h00, 8'h04);
	endtask : t_pair

	// Reset in the middle of a long instruction must drop the count and reopen the decoder.
	task t_reset;
		@(negedge clk);
		byte_in = 8'hE3;
		go = 1'b1;
		repeat (3) @(negedge clk);
		go = 1'b0;
		check("busy before reset", 8'(ready_ff), 8'h00);
		rst_n = 1'b0;
		@(negedge clk);
		check("ready in reset", 8'(ready_ff), 8'h01);
		check("dec_valid in reset", 8'(dec_valid_ff), 8'h00);
		check("done in reset", 8'(done_ff), 8'h00);
		check("op in reset", 8'(dec_ff.op), 8'(OP_NONE));
		rst_n = 1'b1;
		@(negedge clk);
		check("ready after reset", 8'(ready_ff), 8'h01);
		run(8'hEB, 1'b0, 8'(OP_SWAP_DE_HL), 8'h00, 8'h00, 8'h00, 8'h04);
	endtask : t_reset

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			print_verdict();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		t_xor();
		t_swap();
		t_sub();
		t_ret();
		t_pair();
		t_reset();
		print_verdict();
	end
endmodule : cpuodt_decode_tb

`default_nettype wire

// ---- verif/cpuodt_progmem.sv ----
// Purpose: Program memory model offering one opcode byte at a time.
// Assumes: A byte is taken on the rising edge where ready_ff is high.
// Notes: A released bus shows the inverse of its last byte, so stale data is never mistaken.
`timescale 1ns/1ps
`default_nettype none

module cpuodt_progmem (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic [7:0] byte_in,
	input wire logic ready_ff,
	output logic op_valid,
	output logic [7:0] op_byte
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			op_valid <= 1'b0;
			op_byte <= 8'h00;
		end else if (op_valid && ready_ff) begin
			op_valid <= 1'b0;
			op_byte <= ~op_byte;
		end else if (go && !op_valid) begin
			op_valid <= 1'b1;
			op_byte <= byte_in;
		end
	end
endmodule : cpuodt_progmem

`default_nettype wire
